// *** design/mxd_datapath.sv ***
// Multiply and exclusive-OR execution slice of an 8-bit core
//
// Functional notes
// - File multiply: accumulator times addressed file register, unsigned.
// - Product is 16 bits; upper byte into product high register.
// - File multiply leaves accumulator and source register unchanged.
// - Multiplies change no status flag.
// - No overflow or carry from multiply; zero product allowed.
// - Access bit 0 takes operand from access bank, bank pointer ignored.
// - Access bit 1 takes operand bank from bank pointer register.
// - Exclusive-OR computes accumulator XOR addressed file register.
// - Exclusive-OR with destination 0 writes accumulator.
// - Exclusive-OR with destination 1 writes file register back.
`timescale 1ns/100ps

module mxd_datapath (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // Instruction fetch
  input  wire logic [15:0]                   instr_i,
  output logic                               instr_take_o,
  // Core state
  input  wire logic [mxd_pkg::BANK_W-1:0]    bank_pointer_reg_i,
  output logic [mxd_pkg::DATA_W-1:0]         wreg_o,
  output logic [mxd_pkg::DATA_W-1:0]         status_o,
  output logic [mxd_pkg::DATA_W-1:0]         product_high_byte_o,
  output logic [mxd_pkg::DATA_W-1:0]         product_low_byte_o,
  // File register port
  output mxd_pkg::mxd_file_req_s             file_req_o,
  input  wire logic [mxd_pkg::DATA_W-1:0]    file_rdata_i
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mxd_pkg::mxd_op_e                op;
    logic                            dest;
    logic [mxd_pkg::DATA_W-1:0]      lit;
    logic [mxd_pkg::ADDR_W-1:0]      addr;
    logic [mxd_pkg::DATA_W-1:0]      opnd;
    logic [mxd_pkg::PROD_W-1:0]      res;
    logic [mxd_pkg::DATA_W-1:0]      wreg;
    logic [mxd_pkg::DATA_W-1:0]      status;
    logic [mxd_pkg::PROD_W-1:0]      prod;
    mxd_pkg::mxd_file_req_s          freq;
  } mxd_state_s;

  mxd_state_s           st_q;
  mxd_state_s           st_d;
  mxd_pkg::mxd_phase_e  phase;

  // Phase sequencer
  mxd_phase_seq u_seq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .phase_o (phase)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [mxd_pkg::BANK_W-1:0] bank;
    bank = mxd_pkg::BANK_LOW;
    st_d = st_q;
    st_d.freq.we = 1'b0;
    case (phase)
      mxd_pkg::PH_DECODE: begin
        st_d.op   = mxd_pkg::OP_NONE;
        st_d.dest = instr_i[mxd_pkg::BIT_DEST];
        st_d.lit  = instr_i[7:0];
        if (instr_i[15:8] == mxd_pkg::OPC_MUL_LIT) begin
          st_d.op = mxd_pkg::OP_MUL_LIT;
        end else if (instr_i[15:9] == mxd_pkg::OPC_MUL_FILE) begin
          st_d.op = mxd_pkg::OP_MUL_FILE;
        end else if (instr_i[15:10] == mxd_pkg::OPC_XOR_FILE) begin
          st_d.op = mxd_pkg::OP_XOR_FILE;
        end
        if (!instr_i[mxd_pkg::BIT_ACCESS]) begin
          bank = (instr_i[7:0] < mxd_pkg::ACCESS_SPLIT) ? mxd_pkg::BANK_LOW
                                                        : mxd_pkg::BANK_SFR;
        end else begin
          bank = bank_pointer_reg_i;
        end
        st_d.addr      = {bank, instr_i[7:0]};
        st_d.freq.addr = {bank, instr_i[7:0]};
      end
      // Operand read
      mxd_pkg::PH_READ: begin
        st_d.opnd = (st_q.op == mxd_pkg::OP_MUL_LIT) ? st_q.lit : file_rdata_i;
      end
      // Process
      mxd_pkg::PH_PROCESS: begin
        if (st_q.op == mxd_pkg::OP_MUL_LIT || st_q.op == mxd_pkg::OP_MUL_FILE) begin
          st_d.res = {mxd_pkg::RST_BYTE, st_q.wreg} * {mxd_pkg::RST_BYTE, st_q.opnd};
        end else begin
          st_d.res = {mxd_pkg::RST_BYTE, st_q.wreg ^ st_q.opnd};
        end
      end
      // Write back
      mxd_pkg::PH_WRITE: begin
        case (st_q.op)
          mxd_pkg::OP_MUL_LIT, mxd_pkg::OP_MUL_FILE: begin
            st_d.prod = st_q.res;
          end
          mxd_pkg::OP_XOR_FILE: begin
            if (!st_q.dest) begin
              st_d.wreg = st_q.res[7:0];
            end else begin
              st_d.freq.we    = 1'b1;
              st_d.freq.wdata = st_q.res[7:0];
            end
            st_d.status[mxd_pkg::FLAG_N] = st_q.res[7];
            st_d.status[mxd_pkg::FLAG_Z] = (st_q.res[7:0] == mxd_pkg::RST_BYTE);
          end
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign instr_take_o        = (phase == mxd_pkg::PH_DECODE);
  assign wreg_o              = st_q.wreg;
  assign status_o            = st_q.status;
  assign product_high_byte_o = st_q.prod[15:8];
  assign product_low_byte_o  = st_q.prod[7:0];
  assign file_req_o          = st_q.freq;

  // ****************************************
  // Assertions
  // ****************************************
  property p_mul_product;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_PROCESS && st_q.op != mxd_pkg::OP_NONE
      && st_q.op != mxd_pkg::OP_XOR_FILE)
      |=> ##1 (st_q.prod == {8'h00, $past(st_q.wreg, 2)} * {8'h00, $past(st_q.opnd, 2)});
  endproperty
  a_mul_product: assert property (p_mul_product) else $error("product mismatch");

  property p_mul_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_WRITE && st_q.op != mxd_pkg::OP_XOR_FILE)
      |=> $stable(st_q.status) && $stable(st_q.wreg) && !file_req_o.we;
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply changed state");

  property p_access_bank;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_DECODE && !instr_i[mxd_pkg::BIT_ACCESS]
      && instr_i[7:0] < mxd_pkg::ACCESS_SPLIT)
      |=> st_q.addr[11:8] == mxd_pkg::BANK_LOW;
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

  property p_bsr_bank;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_DECODE && instr_i[mxd_pkg::BIT_ACCESS])
      |=> st_q.addr[11:8] == $past(bank_pointer_reg_i);
  endproperty
  a_bsr_bank: assert property (p_bsr_bank) else $error("bank pointer ignored");

  property p_xor_to_w;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_PROCESS && st_q.op == mxd_pkg::OP_XOR_FILE && !st_q.dest)
      |=> ##1 wreg_o == ($past(st_q.wreg, 2) ^ $past(st_q.opnd, 2));
  endproperty
  a_xor_to_w: assert property (p_xor_to_w) else $error("xor to accumulator wrong");

  property p_xor_to_f;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_WRITE && st_q.op == mxd_pkg::OP_XOR_FILE && st_q.dest)
      |=> file_req_o.we && file_req_o.wdata == $past(st_q.res[7:0]) && $stable(wreg_o);
  endproperty
  a_xor_to_f: assert property (p_xor_to_f) else $error("xor to file wrong");

  property p_xor_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (phase == mxd_pkg::PH_WRITE && st_q.op == mxd_pkg::OP_XOR_FILE)
      |=> status_o[mxd_pkg::FLAG_Z] == ($past(st_q.res[7:0]) == 8'h00)
          && status_o[mxd_pkg::FLAG_N] == $past(st_q.res[7]);
  endproperty
  a_xor_zero: assert property (p_xor_zero) else $error("xor flags wrong");

  property p_one_cycle;
    @(posedge clk_i) disable iff (!rst_n_i)
    instr_take_o |=> !instr_take_o [*3] ##1 instr_take_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("cycle length wrong");

  c_mul_lit:  cover property (@(posedge clk_i) disable iff (!rst_n_i)
                              st_q.op == mxd_pkg::OP_MUL_LIT && phase == mxd_pkg::PH_WRITE);
  c_mul_file: cover property (@(posedge clk_i) disable iff (!rst_n_i)
                              st_q.op == mxd_pkg::OP_MUL_FILE && phase == mxd_pkg::PH_WRITE);
  c_xor_file: cover property (@(posedge clk_i) disable iff (!rst_n_i) file_req_o.we);

endmodule : mxd_datapath

// *** design/mxd_phase_seq.sv ***
// Four-phase instruction cycle sequencer
`timescale 1ns/100ps

module mxd_phase_seq (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Phase output
  output mxd_pkg::mxd_phase_e     phase_o
);

  typedef struct packed {
    mxd_pkg::mxd_phase_e ph;
  } mxd_seq_state_s;

  mxd_seq_state_s st_q;
  mxd_seq_state_s st_d;

  // Next phase
  always_comb begin
    st_d = st_q;
    case (st_q.ph)
      mxd_pkg::PH_DECODE:  st_d.ph = mxd_pkg::PH_READ;
      mxd_pkg::PH_READ:    st_d.ph = mxd_pkg::PH_PROCESS;
      mxd_pkg::PH_PROCESS: st_d.ph = mxd_pkg::PH_WRITE;
      mxd_pkg::PH_WRITE:   st_d.ph = mxd_pkg::PH_DECODE;
      default:             st_d.ph = mxd_pkg::PH_DECODE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q.ph <= mxd_pkg::PH_DECODE;
    end else begin
      st_q <= st_d;
    end
  end

  assign phase_o = st_q.ph;

endmodule : mxd_phase_seq

// *** design/mxd_pkg.sv ***
// Package for the multiply / exclusive-OR datapath slice
package mxd_pkg;

  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PROD_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;

  // Opcode fields of the 16-bit instruction word
  localparam logic [7:0] OPC_MUL_LIT  = 8'h0D;  // 0000 1101 kkkk kkkk
  localparam logic [6:0] OPC_MUL_FILE = 7'h01;  // 0000 001a ffff ffff
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;  // 0001 10da ffff ffff
  localparam int unsigned BIT_ACCESS  = 8;
  localparam int unsigned BIT_DEST    = 9;

  // Access bank: low offsets map to bank 0, high ones to the SFR bank
  localparam logic [7:0]        ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] BANK_LOW     = 4'h0;
  localparam logic [BANK_W-1:0] BANK_SFR     = 4'hF;

  // Status flag positions
  localparam int unsigned FLAG_N = 4;
  localparam int unsigned FLAG_Z = 2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PROD_W-1:0] RST_PROD = 16'h0000;

  // Instruction cycle phases
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } mxd_phase_e;

  // Decoded operation
  typedef enum logic [1:0] {
    OP_NONE,
    OP_MUL_LIT,
    OP_MUL_FILE,
    OP_XOR_FILE
  } mxd_op_e;

  // File-register port request
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mxd_file_req_s;

endpackage : mxd_pkg

// *** tb/test_mxd_datapath.sv ***
// Self-checking testbench for the multiply / exclusive-OR datapath
`timescale 1ns/100ps

module test_mxd_datapath;
  // ****************************************
  // Signals and reference model state
  // ****************************************
  logic                  clk_i;
  logic                  rst_n_i;
  logic [15:0]           instr;
  logic                  take;
  logic [3:0]            bank;
  logic [7:0]            wreg, status, product_high_byte, product_low_byte, rdata;
  mxd_pkg::mxd_file_req_s req;
  logic [7:0]            mem [4096];
  int                    exp_mem [4096];
  int                    w_m, st_m, prod_m, i, bad_count, num_checks;

  mxd_datapath u_mxd_datapath (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr), .instr_take_o(take),
    .bank_pointer_reg_i(bank), .wreg_o(wreg), .status_o(status),
    .product_high_byte_o(product_high_byte), .product_low_byte_o(product_low_byte),
    .file_req_o(req), .file_rdata_i(rdata)
  );

  // Clock and file memory beside the datapath
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;
  assign rdata = mem[req.addr];
  always @(posedge clk_i) begin
    if (req.we === 1'b1) mem[req.addr] <= req.wdata;
  end

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input int exp, input string what);
    num_checks++;
    if (got !== 16'(exp)) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, 16'(exp));
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Run one instruction on design and model, then compare all results
  task automatic exec(input logic [15:0] ins, input logic [3:0] bk);
    int a, r, n, fop, wr;
    fop = 1;
    wr = 0;
    a = ins[8] ? {bk, ins[7:0]} : {(ins[7:0] < 8'h80) ? 4'h0 : 4'hF, ins[7:0]};
    if (ins[15:8] == mxd_pkg::OPC_MUL_LIT) begin
      prod_m = w_m * ins[7:0];
      fop = 0;
    end else if (ins[15:9] == mxd_pkg::OPC_MUL_FILE) begin
      prod_m = w_m * exp_mem[a];
    end else if (ins[15:10] == mxd_pkg::OPC_XOR_FILE) begin
      r = w_m ^ exp_mem[a];
      st_m = ((r >> 7) << mxd_pkg::FLAG_N) | ((r == 0) << mxd_pkg::FLAG_Z);
      if (ins[9]) begin
        wr = 1;
        exp_mem[a] = r;
      end else w_m = r;
    end else fop = 0;
    for (n = 0; n < 8 && take !== 1'b1; n++) @(posedge clk_i) #1;
    if (take !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t no instruction slot", $time);
      end_sim();
    end
    instr = ins;
    bank = bk;
    // Take edge plus three: results stand while the next slot is open
    repeat (4) @(posedge clk_i);
    #1;
    chk(wreg, w_m, "wreg");
    chk(status, st_m, "status");
    chk({product_high_byte, product_low_byte}, prod_m, "product");
    chk(req.we, wr, "write strobe");
    if (fop) chk(req.addr, a, "file address");
    if (wr) chk(req.wdata, r, "write data");
  endtask : exec

  task automatic poke(input int a, input int v);
    mem[a] = v[7:0];
    exp_mem[a] = v & 255;
  endtask : poke

  // Load the accumulator through an exclusive-OR into it
  task automatic setw(input int v);
    poke(12'h010, w_m ^ v);
    exec(16'h1810, 4'h0);
  endtask : setw

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_i = 1'b0;
    instr = 16'h0000;
    bank = 4'h0;
    w_m = 0;
    st_m = 0;
    prod_m = 0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(94329));
    for (i = 0; i < 4096; i++) poke(i, $urandom);
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    setw(8'hE2);
    exec(16'h0DC4, 4'h3);
    setw(8'hC4);
    poke(12'h235, 8'hB5);
    exec(16'h0335, 4'h2);
    exec(16'h0D00, 4'h0);
    poke(12'hF90, 8'hAF);
    exec(16'h1A90, 4'h5);
    exec(16'h1890, 4'h5);
    exec(16'hFFFF, 4'h1);
    for (i = 0; i < 60; i++) begin
      case ($urandom_range(0, 2))
        0: exec({8'h0D, 8'($urandom)}, 4'($urandom));
        1: exec({7'h01, 9'($urandom)}, 4'($urandom));
        default: exec({6'h06, 10'($urandom)}, 4'($urandom));
      endcase
    end
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    w_m = 0;
    st_m = 0;
    prod_m = 0;
    chk({wreg, status}, 0, "reset state");
    chk({product_high_byte, product_low_byte}, 0, "reset product");
    chk(req.we, 0, "reset strobe");
    rst_n_i = 1'b1;
    setw(8'h81);
    exec(16'h0DFF, 4'h0);
    end_sim();
  end
endmodule : test_mxd_datapath
